//--- inc/pcc_pkg.sv
// Purpose: shared constants and types for the pwm channel control block
// Assumes: apb slave with 32-bit data, one 8-bit register per aligned word
// Notes: offsets are chosen locally since none are printed
package pcc_pkg;
  localparam logic [11:0] PCC_OFF_CTRL = 12'h000; // channel control
  localparam logic [11:0] PCC_OFF_DUTY_UPPER = 12'h004; // duty upper
  localparam logic [11:0] PCC_OFF_DUTY_LOWER = 12'h008; // duty lower
  localparam logic [11:0] PCC_OFF_TIMER = 12'h00c; // period timer count, read only
  localparam logic [11:0] PCC_OFF_LIMIT = 12'h010; // period limit
  localparam logic [11:0] PCC_OFF_SCALE = 12'h014; // prescale divider
  localparam int PCC_BIT_ENABLE = 7;
  localparam int PCC_BIT_DRIVE = 6;
  localparam int PCC_BIT_LEVEL = 5;
  localparam int PCC_BIT_INVERT = 4;
  localparam logic [7:0] PCC_CTRL_RESET = 8'h00;
  localparam logic [7:0] PCC_CTRL_WMASK = 8'hd0; // writable control bits
  localparam logic [7:0] PCC_LOWER_MASK = 8'hc0; // stored duty lower bits
  localparam logic [7:0] PCC_LIMIT_RESET = 8'hff;
  localparam logic [7:0] PCC_SCALE_RESET = 8'h00;
  localparam int PCC_SUB_W = 2; // sub-count bits below the timer
endpackage : pcc_pkg

//--- inc/pcc_tick_if.sv
// Purpose: timebase signals shared between the timer and the channel core
// Assumes: single clock domain
// Notes: all signals are one-cycle or level signals on ref clock
`timescale 1ns/10ps
`default_nettype none
interface pcc_tick_if;
  logic [7:0] count; // period timer count
  logic [1:0] sub; // sub-count bits
  logic wrap; // pulse: timer matched limit and count is already zero in this cycle
  logic step; // pulse: time base advanced
  modport timer (output count, output sub, output wrap, output step);
  modport chan (input count, input sub, input wrap, input step);
endinterface : pcc_tick_if
`default_nettype wire

//--- src/pcc_timebase.sv
// Purpose: 10-bit time base: 8-bit period timer count with two sub bits
// Assumes: limit and scale come from registers on the same clock
// Notes: scale divides the ref clock; 0 advances every cycle
`timescale 1ns/10ps
`default_nettype none
module pcc_timebase
  import pcc_pkg::*;
(
  input wire logic clk_i, // ref clock
  input wire logic rst_i, // async reset, high
  input wire logic [7:0] limit_i, // period limit
  input wire logic [7:0] scale_i, // prescale divider
  pcc_tick_if.timer tb // time base out
);
  typedef struct packed {
    logic [7:0] pre;
    logic [7:0] count;
    logic [1:0] sub;
    logic wrap;
    logic step;
  } pcc_tb_state_t;
  pcc_tb_state_t st_reg, st_next;

  // prescaler gives a one-cycle step, sub bits roll into the count
  always_comb begin
    st_next = st_reg;
    st_next.wrap = 1'b0;
    st_next.step = 1'b0;
    if (st_reg.pre >= scale_i) begin
      st_next.pre = 8'h00;
      st_next.step = 1'b1;
      st_next.sub = st_reg.sub + 2'h1;
      if (st_reg.sub == 2'h3) begin
        if (st_reg.count >= limit_i) begin
          st_next.count = 8'h00;
          st_next.wrap = 1'b1; // count matched limit: wrap now
        end else begin
          st_next.count = st_reg.count + 8'h01;
        end
      end
    end else begin
      st_next.pre = st_reg.pre + 8'h01;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tb.count = st_reg.count;
  assign tb.sub = st_reg.sub;
  assign tb.wrap = st_reg.wrap;
  assign tb.step = st_reg.step;
endmodule : pcc_timebase
`default_nettype wire

//--- src/pcc_channel_core.sv
// Purpose: one channel's shadow duty buffer and waveform level
// Assumes: duty inputs are the software registers
// Notes: level is the raw active-high waveform before inversion
`timescale 1ns/10ps
`default_nettype none
module pcc_channel_core
  import pcc_pkg::*;
(
  input wire logic clk_i, // ref clock
  input wire logic rst_i, // async reset, high
  input wire logic enable_i, // channel enable
  input wire logic [9:0] duty_i, // software duty value
  input wire logic [7:0] limit_i, // period limit
  pcc_tick_if.chan tb, // time base in
  output logic level_o // raw waveform level
);
  typedef struct packed {
    logic [9:0] shadow;
    logic level;
  } pcc_core_state_t;
  pcc_core_state_t st_reg, st_next;
  logic [9:0] now;

  assign now = {tb.count, tb.sub};

  // set at wrap, clear at duty match; duty at or above period never clears
  always_comb begin
    st_next = st_reg;
    if (tb.wrap) begin
      st_next.shadow = duty_i;
      st_next.level = enable_i && (duty_i != 10'h000);
    end else if (tb.step && (now == st_reg.shadow)) begin
      // level rises one cycle after the wrap, so the match on now keeps the width at duty
      if ({1'b0, st_reg.shadow} <= {1'b0, limit_i, 2'b11}) begin
        st_next.level = 1'b0;
      end
    end
    if (!enable_i) begin
      st_next.level = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level_o = st_reg.level;

  property p_shadow_load;
    @(posedge clk_i) disable iff (rst_i) tb.wrap |=> (st_reg.shadow == $past(duty_i));
  endproperty
  a_shadow_load: assert property (p_shadow_load) else $error("shadow not loaded");

  property p_disabled_low;
    @(posedge clk_i) disable iff (rst_i) !enable_i |=> !st_reg.level;
  endproperty
  a_disabled_low: assert property (p_disabled_low) else $error("level high while off");

  property p_shadow_hold;
    @(posedge clk_i) disable iff (rst_i) !tb.wrap |=> $stable(st_reg.shadow);
  endproperty
  a_shadow_hold: assert property (p_shadow_hold) else $error("shadow changed early");
endmodule : pcc_channel_core
`default_nettype wire

//--- src/pcc_top.sv
// Purpose: apb register file and output stage of one pwm channel
// Assumes: apb3 master, single ref clock, pin input not needed
// Notes: duty registers survive RST_I; PWR_RST_I marks power-on reset
//
// What this block does
// - control register resets to zero; enable, drive, invert writable; level read only
// - control bits 3 to 0 ignore writes and read zero
// - duty upper holds the eight top bits of the duty value
// - duty lower bits 7 and 6 are the two bottom duty bits
// - duty lower bits 5 to 0 store nothing and read zero
// - duty registers undefined at power-on, kept over other resets
// - invert bit makes the output active low
// - drive enable low releases the pin to the port latch
// - output set at timer wrap, cleared at duty match, stays on if duty large
// - duty writes reach the waveform via a shadow loaded after limit match
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module pcc_top
  import pcc_pkg::*;
(
  input wire logic REF_CLK_I, // 125 MHz clock
  input wire logic RST_I, // async reset, high
  input wire logic PWR_RST_I, // async power-on or brown-out reset, high
  input wire logic PSEL_I, // apb select
  input wire logic PENABLE_I, // apb enable
  input wire logic PWRITE_I, // apb write
  input wire logic [11:0] PADDR_I, // apb byte address
  input wire logic [31:0] PWDATA_I, // apb write data
  input wire logic [3:0] PSTRB_I, // apb byte strobes
  output logic [31:0] PRDATA_O, // apb read data
  output logic PREADY_O, // apb ready
  output logic PSLVERR_O, // apb error
  input wire logic PORT_LATCH_I, // port latch level
  output logic PIN_O, // pin level
  output logic PIN_OE_O, // pin driven by this channel
  output logic WAVE_O // polarity-adjusted waveform
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] limit;
    logic [7:0] scale;
    logic [31:0] rdata;
    logic err;
  } pcc_regs_t;
  typedef struct packed {
    logic [7:0] upper;
    logic [7:0] lower;
  } pcc_duty_t;

  pcc_regs_t st_reg, st_next;
  pcc_duty_t duty_reg, duty_next;
  logic access, wr, rd, hit, level, out_level;
  pcc_tick_if tick ();

  // only the low byte lane carries a register
  function automatic logic [7:0] merge8(input logic [7:0] old, input logic [7:0] nw,
                                        input logic [7:0] mask);
    merge8 = (old & ~mask) | (nw & mask);
  endfunction : merge8

  assign access = PSEL_I && PENABLE_I;
  assign wr = access && PWRITE_I && PSTRB_I[0];
  assign rd = access && !PWRITE_I;
  assign hit = (PADDR_I == PCC_OFF_CTRL) || (PADDR_I == PCC_OFF_DUTY_UPPER) ||
               (PADDR_I == PCC_OFF_DUTY_LOWER) || (PADDR_I == PCC_OFF_TIMER) ||
               (PADDR_I == PCC_OFF_LIMIT) || (PADDR_I == PCC_OFF_SCALE);

  // register writes in the access cycle, read-data capture during the setup cycle
  always_comb begin
    st_next = st_reg;
    st_next.err = 1'b0;
    if (wr && PADDR_I == PCC_OFF_CTRL) begin
      st_next.ctrl = merge8(st_reg.ctrl, PWDATA_I[7:0], PCC_CTRL_WMASK);
    end
    if (wr && PADDR_I == PCC_OFF_LIMIT) begin
      st_next.limit = PWDATA_I[7:0];
    end
    if (wr && PADDR_I == PCC_OFF_SCALE) begin
      st_next.scale = PWDATA_I[7:0];
    end
    st_next.ctrl[PCC_BIT_LEVEL] = out_level;
    st_next.ctrl[3:0] = 4'h0;
    if (PSEL_I && !PENABLE_I) begin
      st_next.err = !hit;
      unique case (PADDR_I)
        PCC_OFF_CTRL: st_next.rdata = {24'h000000, st_reg.ctrl};
        PCC_OFF_DUTY_UPPER: st_next.rdata = {24'h000000, duty_reg.upper};
        PCC_OFF_DUTY_LOWER: st_next.rdata = {24'h000000, duty_reg.lower & PCC_LOWER_MASK};
        PCC_OFF_TIMER: st_next.rdata = {24'h000000, tick.count};
        PCC_OFF_LIMIT: st_next.rdata = {24'h000000, st_reg.limit};
        PCC_OFF_SCALE: st_next.rdata = {24'h000000, st_reg.scale};
        default: st_next.rdata = 32'h00000000;
      endcase
    end
  end

  // duty bytes; lower keeps only its two stored bits
  always_comb begin
    duty_next = duty_reg;
    if (wr && PADDR_I == PCC_OFF_DUTY_UPPER) begin
      duty_next.upper = PWDATA_I[7:0];
    end
    if (wr && PADDR_I == PCC_OFF_DUTY_LOWER) begin
      duty_next.lower = PWDATA_I[7:0] & PCC_LOWER_MASK;
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st_reg <= '{ctrl: PCC_CTRL_RESET, limit: PCC_LIMIT_RESET, scale: PCC_SCALE_RESET,
                  rdata: 32'h00000000, err: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  // duty is cleared only by power-on reset, so ordinary resets keep it
  always_ff @(posedge REF_CLK_I or posedge PWR_RST_I) begin
    if (PWR_RST_I) begin
      duty_reg <= '0;
    end else begin
      duty_reg <= duty_next;
    end
  end

  pcc_timebase u_timebase (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .limit_i(st_reg.limit),
    .scale_i(st_reg.scale),
    .tb(tick.timer)
  );

  pcc_channel_core u_core (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .enable_i(st_reg.ctrl[PCC_BIT_ENABLE]),
    .duty_i({duty_reg.upper, duty_reg.lower[7:6]}),
    .limit_i(st_reg.limit),
    .tb(tick.chan),
    .level_o(level)
  );

  // inversion applies after the waveform; pin falls back to the latch
  assign out_level = level ^ st_reg.ctrl[PCC_BIT_INVERT];
  assign WAVE_O = out_level;
  assign PIN_OE_O = st_reg.ctrl[PCC_BIT_DRIVE];
  assign PIN_O = st_reg.ctrl[PCC_BIT_DRIVE] ? out_level : PORT_LATCH_I;
  assign PRDATA_O = st_reg.rdata;
  assign PREADY_O = 1'b1; // zero wait states
  assign PSLVERR_O = access && st_reg.err;

  property p_ctrl_low_zero;
    @(posedge REF_CLK_I) disable iff (RST_I) st_reg.ctrl[3:0] == 4'h0;
  endproperty
  a_ctrl_low_zero: assert property (p_ctrl_low_zero) else $error("ctrl low bits set");

  property p_lower_zero;
    @(posedge REF_CLK_I) disable iff (PWR_RST_I) duty_reg.lower[5:0] == 6'h00;
  endproperty
  a_lower_zero: assert property (p_lower_zero) else $error("duty lower low bits set");

  sequence s_upper_write;
    wr && PADDR_I == PCC_OFF_DUTY_UPPER;
  endsequence
  property p_upper_store;
    @(posedge REF_CLK_I) disable iff (PWR_RST_I) s_upper_write |=> duty_reg.upper == $past(PWDATA_I[7:0]);
  endproperty
  a_upper_store: assert property (p_upper_store) else $error("duty upper not stored");

  property p_lower_store;
    @(posedge REF_CLK_I) disable iff (PWR_RST_I)
      (wr && PADDR_I == PCC_OFF_DUTY_LOWER) |=> duty_reg.lower[7:6] == $past(PWDATA_I[7:6]);
  endproperty
  a_lower_store: assert property (p_lower_store) else $error("duty lower not stored");

  property p_invert;
    @(posedge REF_CLK_I) disable iff (RST_I) WAVE_O == (level ^ st_reg.ctrl[PCC_BIT_INVERT]);
  endproperty
  a_invert: assert property (p_invert) else $error("polarity wrong");

  property p_release;
    @(posedge REF_CLK_I) disable iff (RST_I) !PIN_OE_O |-> PIN_O == PORT_LATCH_I;
  endproperty
  a_release: assert property (p_release) else $error("pin not released");

  property p_level_ro;
    @(posedge REF_CLK_I) disable iff (RST_I) ##1 st_reg.ctrl[PCC_BIT_LEVEL] == $past(out_level);
  endproperty
  a_level_ro: assert property (p_level_ro) else $error("level bit not live");

  property p_wrap_set;
    @(posedge REF_CLK_I) disable iff (RST_I)
      (tick.wrap && st_reg.ctrl[PCC_BIT_ENABLE] && {duty_reg.upper, duty_reg.lower[7:6]} != 10'h000
       && !(wr && PADDR_I == PCC_OFF_CTRL)) |=> level;
  endproperty
  a_wrap_set: assert property (p_wrap_set) else $error("no set at wrap");
endmodule : pcc_top
`default_nettype wire

//--- tb/pcc_far_model.sv
// Purpose: far side of the channel: the port latch behind the pin
// Assumes: the latch is clocked by the ref clock
// Notes: the level changes every cycle so a stale pin never passes as a match
`timescale 1ns/10ps
`default_nettype none
module pcc_far_model (
  input wire logic clk_i, // ref clock
  output logic latch_o // port latch level
);
  // toggling pattern, a pin left on the waveform shows up at once
  initial latch_o = 1'b0;
  always @(posedge clk_i) begin
    latch_o <= ~latch_o;
  end
endmodule : pcc_far_model
`default_nettype wire

//--- tb/tb.sv
// Purpose: self-checking bench for the pwm channel register block
// Assumes: apb slave answers in its own time, waits are bounded by a timeout
// Notes: period limit is cut to 3 so one period is 16 cycles
`timescale 1ns/10ps
`default_nettype none
module tb;
  import pcc_pkg::*;
  localparam logic [7:0] LIM = 8'h03;
  localparam int WIN = 2 * (LIM + 1) * 4; // two full periods
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic pwr_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, latch, pin, pin_oe, wave, err_seen;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  pcc_top u_dut (.REF_CLK_I(ref_clk), .RST_I(rst), .PWR_RST_I(pwr_rst),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PSTRB_I(4'hf), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .PORT_LATCH_I(latch), .PIN_O(pin), .PIN_OE_O(pin_oe),
    .WAVE_O(wave));
  pcc_far_model u_far (.clk_i(ref_clk), .latch_o(latch));
  // clock and a hard ceiling so a hung handshake still reaches the verdict
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      end_sim();
    end
  end
  task automatic end_sim();
    if (err_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  task automatic set_duty(input logic [9:0] d);
    apb(1'b1, PCC_OFF_DUTY_UPPER, {24'h0, d[9:2]});
    apb(1'b1, PCC_OFF_DUTY_LOWER, {24'h0, d[1:0], 6'h00});
  endtask : set_duty
  // counts active cycles over two periods, after the shadow had time to load
  task automatic measure(input int exp);
    int n;
    n = 0;
    repeat (WIN + 16) @(posedge ref_clk);
    for (int i = 0; i < WIN; i++) begin
      @(posedge ref_clk);
      if (wave === 1'b1) n++;
    end
    check(32'(n), 32'(exp));
  endtask : measure
  task automatic t_reset_values();
    apb(1'b0, PCC_OFF_CTRL, 32'h0);
    check(rd, 32'h00000000);
    check({31'h0, pin_oe}, 32'h0);
    check({31'h0, wave}, 32'h0);
  endtask : t_reset_values
  task automatic t_ctrl_access();
    apb(1'b1, PCC_OFF_CTRL, 32'h0000005f);
    apb(1'b0, PCC_OFF_CTRL, 32'h0);
    check(rd, 32'h00000070);
    check({31'h0, pin_oe}, 32'h1);
    check({31'h0, wave}, 32'h1);
    check({31'h0, pin}, {31'h0, wave});
    apb(1'b1, PCC_OFF_CTRL, 32'h0000000f);
    apb(1'b0, PCC_OFF_CTRL, 32'h0);
    check(rd, 32'h00000000);
    repeat (3) begin
      @(posedge ref_clk);
      #1 check({31'h0, pin}, {31'h0, latch});
    end
  endtask : t_ctrl_access
  task automatic t_duty_regs();
    apb(1'b1, PCC_OFF_DUTY_UPPER, 32'h000000a5);
    apb(1'b1, PCC_OFF_DUTY_LOWER, 32'h000000ff);
    apb(1'b0, PCC_OFF_DUTY_UPPER, 32'h0);
    check(rd, 32'h000000a5);
    apb(1'b0, PCC_OFF_DUTY_LOWER, 32'h0);
    check(rd, 32'h000000c0);
    apb(1'b0, 12'h100, 32'h0);
    check({31'h0, err_seen}, 32'h1);
    check(rd, 32'h00000000);
  endtask : t_duty_regs
  // ordinary reset keeps duty, power-on reset clears it (zero stands for unknown)
  task automatic t_resets();
    apb(1'b1, PCC_OFF_CTRL, 32'h000000d0);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    apb(1'b0, PCC_OFF_DUTY_UPPER, 32'h0);
    check(rd, 32'h000000a5);
    apb(1'b0, PCC_OFF_DUTY_LOWER, 32'h0);
    check(rd, 32'h000000c0);
    apb(1'b0, PCC_OFF_CTRL, 32'h0);
    check(rd, 32'h00000000);
    pwr_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    pwr_rst <= 1'b0;
    @(posedge ref_clk);
    apb(1'b0, PCC_OFF_DUTY_UPPER, 32'h0);
    check(rd, 32'h00000000);
  endtask : t_resets
  // duty 6 uses the low pair; 16 reaches the period and never clears
  task automatic t_wave();
    apb(1'b1, PCC_OFF_LIMIT, {24'h0, LIM});
    set_duty(10'd6);
    apb(1'b1, PCC_OFF_CTRL, 32'h000000c0);
    measure(12);
    check({31'h0, pin}, {31'h0, wave});
    apb(1'b1, PCC_OFF_CTRL, 32'h000000d0);
    measure(WIN - 12);
    apb(1'b1, PCC_OFF_CTRL, 32'h000000c0);
    set_duty(10'd16);
    measure(WIN);
    set_duty(10'd0);
    measure(0);
    set_duty(10'd6);
    apb(1'b1, PCC_OFF_CTRL, 32'h00000040);
    measure(0);
  endtask : t_wave
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    pwr_rst <= 1'b0;
    @(posedge ref_clk);
    t_reset_values();
    t_ctrl_access();
    t_duty_regs();
    t_resets();
    t_wave();
    end_sim();
  end
endmodule : tb
`default_nettype wire
